/* File: ebc_top.sv */
// External bus controller: area decode, access sequencer and pin drive
`timescale 1ns/1ps
// Operation
// - Multiplex select 0 gives normal extension, 1 gives multiplexed.
// - Normal mode: 256-kbyte area decoded by 18 lines plus its select.
// - Normal mode: CP area H'FFC000-H'FFDFFF, 13 lines plus CP select.
// - Normal mode: IO area H'FFF000-H'FFF7FF with the IO select.
// - Multiplexed: only 64-kbyte window, CP area and IO area reachable.
// - Multiplexed lines form an 8-line or a 16-line combined bus.
// - One bit inverts the three area selects, another the hold signal.
// - Multiplexed: 2-state address, data 2 states or 3 plus waits.
// - Address-phase wait bit adds one state to the address phase.
// - Each area chooses 2-state or 3-state accesses.
// - Each area in 3-state access inserts its own programmed number of waits.
// - Normal mode basic areas may burst with 1-state or 2-state cycles.
// - Normal mode may insert an idle state between read and write.
// - Arbiter grants the bus to CPU or transfer controller, one at once.
// - Address strobe only with IO enable 0, not for selected areas.
// - IO enable 1 asserts the IO select on IO area accesses.
// - CP enable 1 asserts the CP select on CP area accesses.
// - Large enable 1 asserts the large select on its accesses.
// - Read strobe is asserted on every external read.
// - Write strobes follow the byte lanes that carry data.
// - Hold marks the address on shared lines, which then carry data.
module ebc_top
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire ebc_cfg_t cfg,
  input wire ebc_req_t cpu_req,
  input wire ebc_req_t tc_req,
  output logic cpu_done,
  output logic tc_done,
  output logic [DATA_W-1:0] rdata,
  output logic access_error,
  output logic bus_master_tc,
  output logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] muxed_addr_data_lines_in,
  output logic [DATA_W-1:0] muxed_addr_data_lines_out,
  output logic [1:0] muxed_addr_data_lines_oe,
  output logic address_strobe_n,
  output logic read_strobe_n,
  output logic upper_byte_write_strobe_n,
  output logic lower_byte_write_strobe_n,
  output logic large_area_select_n,
  output logic cp_area_select_n,
  output logic io_window_select_n,
  output logic address_hold_n,
  input wire logic wait_request_n
);
  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [23:0] a,
                               input logic [23:0] base,
                               input logic [23:0] mask);
    hit = ((a & mask) == base);
  endfunction

  function automatic logic [WAIT_W-1:0] wait_of(
      input logic [BASIC_AREAS*WAIT_W-1:0] w,
      input logic [2:0] idx);
    wait_of = w[idx*WAIT_W +: WAIT_W];
  endfunction

  // Pin level of a select or hold under its polarity bit
  function automatic logic pin_level(input logic active,
                                     input logic flip);
    pin_level = ~active ^ flip;
  endfunction

  // Phase of a sequencer state, used on the state about to be entered
  function automatic logic addr_phase(input ebc_state_t s);
    addr_phase = (s == ST_MA1) | (s == ST_MA2) | (s == ST_MAW);
  endfunction

  function automatic logic data_phase(input ebc_state_t s);
    data_phase = (s == ST_T1) | (s == ST_T2) | (s == ST_TW) |
                 (s == ST_T3);
  endfunction

  // ==========================================================
  // Arbiter
  logic arb_start;
  logic arb_tc;

  ebc_arbiter u_arb (
    .mclk(mclk),
    .rstn(rstn),
    .cpu_valid(cpu_req.valid),
    .tc_valid(tc_req.valid),
    .release_bus(cpu_done | tc_done),
    .start(arb_start),
    .owner_tc(arb_tc)
  );

  // ==========================================================
  // State
  ebc_state_t state;
  ebc_state_t next_state;
  ebc_req_t held;
  logic [WAIT_W-1:0] wcnt;
  logic burst_cyc;
  logic last_read;
  logic [ADDR_W-1:0] last_addr;

  // ==========================================================
  // Access decode
  // The request in flight is held from the start edge; while idle the
  // incoming request is looked at so that pins settle with the first state.
  wire mux = cfg.mux_mode_select;
  wire ebc_req_t new_req = arb_tc ? tc_req : cpu_req;
  wire ebc_req_t cur_req = (state == ST_IDLE) ? new_req : held;
  wire [ADDR_W-1:0] ca = cur_req.addr;
  wire in_io = hit(ca, IO_BASE, IO_MASK);
  wire in_cp = hit(ca, CP_BASE, CP_MASK);
  wire in_large_n = hit(ca, LARGE_BASE, LARGE_MASK);
  wire in_large_m = hit(ca, LARGE_BASE, MUXL_MASK);
  wire in_large = mux ? in_large_m : in_large_n;
  wire ebc_area_t cur_area = in_io ? AREA_IO :
                             in_cp ? AREA_CP :
                             in_large ? AREA_LARGE : AREA_BASIC;
  // Basic space does not exist on the multiplexed bus
  wire unreach = mux & (cur_area == AREA_BASIC);
  wire [2:0] area_idx = ca[ADDR_W-1:BASIC_SEL_LSB];
  wire cur_three = cfg.three_state[area_idx];
  wire [WAIT_W-1:0] cur_waits = wait_of(cfg.prog_waits, area_idx);
  wire large_sel = (cur_area == AREA_LARGE) & cfg.large_area_enable;
  wire cp_sel = (cur_area == AREA_CP) & cfg.cp_area_enable;
  wire io_sel = (cur_area == AREA_IO) & cfg.io_window_enable;

  // ==========================================================
  // Burst and idle decisions
  // Burst is refused for the large and CP areas while their selects are
  // enabled, as those devices are not expected to be burst ROMs.
  wire burst_area = (cur_area == AREA_BASIC) |
                    ((cur_area == AREA_LARGE) & !cfg.large_area_enable) |
                    ((cur_area == AREA_CP) & !cfg.cp_area_enable);
  wire burst_ok = cfg.burst_rom_enable & !mux & burst_area;
  wire same_hi = (ca[ADDR_W-1:BURST8_LSB] ==
                  last_addr[ADDR_W-1:BURST8_LSB]);
  wire same_mid = (ca[BURST4_LSB] == last_addr[BURST4_LSB]);
  wire same_blk = same_hi & (cfg.burst_eight_words | same_mid);
  wire burst_hit = burst_ok & !cur_req.write & last_read & same_blk;
  wire need_idle = cfg.idle_insert & !mux & last_read &
                   cur_req.write;
  wire cur_burst = (state == ST_IDLE) ? burst_hit : burst_cyc;

  // Program waits and the pin are honoured together: a wait state is added while either asks
  wire stretch = (wcnt != 2'h0) | !wait_request_n;
  wire capture = (state == ST_IDLE) & arb_start;
  wire err_now = capture & unreach;

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (arb_start && !unreach) begin
          if (need_idle) begin
            next_state = ST_GAP;
          end else if (mux) begin
            next_state = ST_MA1;
          end else begin
            next_state = ST_T1;
          end
        end
      end
      ST_GAP: next_state = ST_T1;
      ST_MA1: next_state = ST_MA2;
      ST_MA2: begin
        if (cfg.addr_phase_wait_bit) begin
          next_state = ST_MAW;
        end else begin
          next_state = ST_T1;
        end
      end
      ST_MAW: next_state = ST_T1;
      ST_T1: begin
        if (burst_cyc && !cfg.burst_two_state) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_T2;
        end
      end
      ST_T2: begin
        if (burst_cyc || !cur_three) begin
          next_state = ST_IDLE;
        end else if (stretch) begin
          next_state = ST_TW;
        end else begin
          next_state = ST_T3;
        end
      end
      ST_TW: begin
        if (stretch) begin
          next_state = ST_TW;
        end else begin
          next_state = ST_T3;
        end
      end
      ST_T3: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  wire finish = (state != ST_IDLE) & (next_state == ST_IDLE);
  wire wdec = (wcnt != 2'h0) &
              (((state == ST_T2) & cur_three & !burst_cyc) |
               (state == ST_TW));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      held <= '0;
      wcnt <= '0;
      burst_cyc <= 1'b0;
    end else if (capture) begin
      held <= new_req;
      wcnt <= cur_waits;
      burst_cyc <= burst_hit;
    end else if (wdec) begin
      wcnt <= wcnt - 2'h1;
    end
  end

  // Only completed accesses count as history for burst and idle choices
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_read <= 1'b0;
      last_addr <= RST_ADDR;
    end else if (finish) begin
      last_read <= !held.write;
      last_addr <= held.addr;
    end
  end

  // ==========================================================
  // Answer to the masters
  wire [BYTE_W-1:0] ad_lo_in = muxed_addr_data_lines_in[BYTE_W-1:0];
  wire [DATA_W-1:0] mux_rd = cfg.mux_bus_wide ? muxed_addr_data_lines_in :
                             {ad_lo_in, ad_lo_in};
  wire [DATA_W-1:0] rd_word = mux ? mux_rd : data_in;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_done <= 1'b0;
      tc_done <= 1'b0;
      access_error <= 1'b0;
      rdata <= RST_DATA;
      bus_master_tc <= 1'b0;
    end else begin
      cpu_done <= (finish | err_now) & !arb_tc;
      tc_done <= (finish | err_now) & arb_tc;
      access_error <= err_now;
      bus_master_tc <= arb_tc;
      if (finish && !held.write) begin
        rdata <= rd_word;
      end
    end
  end

  // ==========================================================
  // Next pin values, taken from the state about to be entered
  wire in_addr = addr_phase(next_state);
  wire in_data = data_phase(next_state);
  wire act = in_addr | in_data;
  wire wr = cur_req.write;
  // A 3-state write holds its strobes off in the first state for setup
  wire wr_on = in_data & wr &
               !(cur_three & !cur_burst & (next_state == ST_T1));
  wire as_on = in_data & !cfg.io_window_enable &
               !large_sel & !cp_sel;
  wire inv = cfg.select_polarity_invert;
  wire n_large_n = pin_level(act & large_sel, inv);
  wire n_cp_n = pin_level(act & cp_sel, inv);
  wire n_io_n = pin_level(act & io_sel, inv);
  wire n_hold_n = pin_level(mux & in_addr,
                            cfg.hold_polarity_invert);
  wire [BYTE_W-1:0] wd_lo = (cfg.mux_bus_wide || cur_req.lo_en) ?
                            cur_req.wdata[BYTE_W-1:0] :
                            cur_req.wdata[DATA_W-1:BYTE_W];
  wire [DATA_W-1:0] n_ad_out = in_addr ? ca[DATA_W-1:0] :
                               {cur_req.wdata[DATA_W-1:BYTE_W], wd_lo};
  wire ad_drive = mux & (in_addr | (in_data & wr));
  wire [1:0] n_ad_oe = {ad_drive & cfg.mux_bus_wide, ad_drive};

  // ==========================================================
  // Address and data registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_out <= RST_ADDR;
      data_out <= RST_DATA;
      data_oe <= 1'b0;
      muxed_addr_data_lines_out <= RST_DATA;
      muxed_addr_data_lines_oe <= RST_AD_OE;
    end else begin
      if (act) begin
        addr_out <= ca;
      end
      data_out <= cur_req.wdata;
      data_oe <= in_data & wr & !mux;
      muxed_addr_data_lines_out <= n_ad_out;
      muxed_addr_data_lines_oe <= n_ad_oe;
    end
  end

  // ==========================================================
  // Strobe and select registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      address_strobe_n <= RST_STROBE_N;
      read_strobe_n <= RST_STROBE_N;
      upper_byte_write_strobe_n <= RST_STROBE_N;
      lower_byte_write_strobe_n <= RST_STROBE_N;
      large_area_select_n <= RST_STROBE_N;
      cp_area_select_n <= RST_STROBE_N;
      io_window_select_n <= RST_STROBE_N;
      address_hold_n <= RST_STROBE_N;
    end else begin
      address_strobe_n <= !as_on;
      read_strobe_n <= !(in_data & !wr);
      upper_byte_write_strobe_n <= !(wr_on & cur_req.hi_en);
      lower_byte_write_strobe_n <= !(wr_on & cur_req.lo_en);
      large_area_select_n <= n_large_n;
      cp_area_select_n <= n_cp_n;
      io_window_select_n <= n_io_n;
      address_hold_n <= n_hold_n;
    end
  end
endmodule

/* File: ebc_pkg.sv */
// Constants, types and state codes of the external bus controller
package ebc_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int WAIT_W = 2;
  localparam int BASIC_AREAS = 8;
  localparam int BASIC_SEL_LSB = 21;
  localparam int BURST4_LSB = 3;
  localparam int BURST8_LSB = 4;

  // ==========================================================
  // Area windows, base and compare mask
  localparam logic [23:0] LARGE_BASE = 24'hF80000;
  localparam logic [23:0] LARGE_MASK = 24'hFC0000;
  localparam logic [23:0] MUXL_MASK = 24'hFF0000;
  localparam logic [23:0] CP_BASE = 24'hFFC000;
  localparam logic [23:0] CP_MASK = 24'hFFE000;
  localparam logic [23:0] IO_BASE = 24'hFFF000;
  localparam logic [23:0] IO_MASK = 24'hFFF800;

  // ==========================================================
  // Reset values
  localparam logic [23:0] RST_ADDR = 24'h000000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic [1:0] RST_AD_OE = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    AREA_BASIC = 2'h0,
    AREA_LARGE = 2'h1,
    AREA_CP = 2'h2,
    AREA_IO = 2'h3
  } ebc_area_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_GAP = 9'h002,
    ST_MA1 = 9'h004,
    ST_MA2 = 9'h008,
    ST_MAW = 9'h010,
    ST_T1 = 9'h020,
    ST_T2 = 9'h040,
    ST_TW = 9'h080,
    ST_T3 = 9'h100
  } ebc_state_t;

  typedef struct packed {
    logic mux_mode_select;
    logic mux_bus_wide;
    logic select_polarity_invert;
    logic hold_polarity_invert;
    logic addr_phase_wait_bit;
    logic io_window_enable;
    logic large_area_enable;
    logic cp_area_enable;
    logic idle_insert;
    logic burst_rom_enable;
    logic burst_two_state;
    logic burst_eight_words;
    logic [BASIC_AREAS-1:0] three_state;
    logic [BASIC_AREAS*WAIT_W-1:0] prog_waits;
  } ebc_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic hi_en;
    logic lo_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebc_req_t;
endpackage

/* File: ebc_arbiter.sv */
// Bus mastership arbiter between the CPU and the transfer controller
`timescale 1ns/1ps
module ebc_arbiter
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cpu_valid,
  input wire logic tc_valid,
  input wire logic release_bus,
  output logic start,
  output logic owner_tc
);
  // ==========================================================
  // Ownership
  // The transfer controller wins a tie so that block moves are not
  // starved by back-to-back fetches of the CPU.
  logic busy;
  wire any_req = cpu_valid | tc_valid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      start <= 1'b0;
      owner_tc <= 1'b0;
    end else begin
      start <= 1'b0;
      if (busy) begin
        if (release_bus) begin
          busy <= 1'b0;
        end
      end else if (any_req) begin
        busy <= 1'b1;
        start <= 1'b1;
        owner_tc <= tc_valid;
      end
    end
  end
endmodule

/* File: ebc_monitor.sv */
// Assertion checker on the external bus controller ports
`timescale 1ns/1ps
module ebc_monitor
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire ebc_cfg_t cfg,
  input wire logic cpu_done,
  input wire logic tc_done,
  input wire logic access_error,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [1:0] muxed_addr_data_lines_oe,
  input wire logic address_strobe_n,
  input wire logic read_strobe_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic lower_byte_write_strobe_n,
  input wire logic large_area_select_n,
  input wire logic cp_area_select_n,
  input wire logic io_window_select_n,
  input wire logic address_hold_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Selects are checked only in low-active polarity: at reset they sit high
  wire pl = !cfg.select_polarity_invert;
  wire [23:0] lmask = cfg.mux_mode_select ? MUXL_MASK : LARGE_MASK;
  wire wr_idle = upper_byte_write_strobe_n && lower_byte_write_strobe_n;
  wire cp_hit = (addr_out & CP_MASK) == CP_BASE;
  sequence s_addr;
    (!address_hold_n && muxed_addr_data_lines_oe != 2'h0) [*2];
  endsequence
  sequence s_data;
    ##[1:2] address_hold_n;
  endsequence
  property p_hold;
    $fell(address_hold_n) && !cfg.hold_polarity_invert |-> s_addr ##0 s_data;
  endproperty
  property p_done;
    cpu_done |=> !cpu_done;
  endproperty
  property p_excl;
    !(cpu_done && tc_done);
  endproperty
  property p_err;
    access_error |-> (cpu_done || tc_done) && $past(read_strobe_n) &&
      $past(upper_byte_write_strobe_n);
  endproperty
  property p_rdwr;
    !read_strobe_n |-> wr_idle;
  endproperty
  property p_cp;
    pl && !cp_area_select_n |-> cp_hit;
  endproperty
  property p_io;
    pl && !io_window_select_n |-> (addr_out & IO_MASK) == IO_BASE;
  endproperty
  property p_large;
    pl && !large_area_select_n |-> (addr_out & lmask) == LARGE_BASE;
  endproperty
  property p_as;
    !address_strobe_n |-> !cfg.io_window_enable &&
      !(cfg.cp_area_enable && cp_hit);
  endproperty
  a_hold: assert property (p_hold) else $error("hold phase");
  a_done: assert property (p_done) else $error("done width");
  a_excl: assert property (p_excl) else $error("two masters");
  a_err: assert property (p_err) else $error("error access");
  a_rdwr: assert property (p_rdwr) else $error("read and write");
  a_cp: assert property (p_cp) else $error("cp select");
  a_io: assert property (p_io) else $error("io select");
  a_large: assert property (p_large) else $error("large sel");
  a_as: assert property (p_as) else $error("addr strobe");
endmodule
bind ebc_top ebc_monitor u_mon (.*);

/* File: ebc_mem_model.sv */
// Behavioural external memory on the far side of the bus
`timescale 1ns/1ps
module ebc_mem_model
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire ebc_cfg_t cfg,
  input wire logic [1:0] slow,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic [DATA_W-1:0] muxed_addr_data_lines_out,
  input wire logic address_hold_n,
  input wire logic read_strobe_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic lower_byte_write_strobe_n,
  output logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] muxed_addr_data_lines_in,
  output logic wait_request_n
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0000;
  logic [7:0] ma = 8'h00;
  logic [1:0] cnt = 2'h0;
  logic busy = 1'b0;
  wire hw = !upper_byte_write_strobe_n;
  wire lw = !lower_byte_write_strobe_n;
  wire [7:0] ix = cfg.mux_mode_select ? ma : addr_out[7:0];
  wire [15:0] wd = data_oe ? data_out : muxed_addr_data_lines_out;
  wire act = !read_strobe_n || hw || lw;
  // Released lines show the inverse of the last value, not a held copy
  assign data_in = read_strobe_n ? ~last : mem[ix];
  assign muxed_addr_data_lines_in = data_in;
  assign wait_request_n = cnt == 2'h0;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(posedge mclk) begin
    if (address_hold_n == cfg.hold_polarity_invert) begin
      ma <= muxed_addr_data_lines_out[7:0];
    end
    if (hw) mem[ix][15:8] <= wd[15:8];
    if (lw) mem[ix][7:0] <= wd[7:0];
    if (!read_strobe_n) last <= mem[ix];
    // Slow device asks for more time once per access, from its first strobe
    if (act && !busy) cnt <= slow;
    else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    busy <= act;
  end
endmodule

/* File: test_external_bus_controller.sv */
// Self-checking bench for the external bus controller
`timescale 1ns/1ps
module test_external_bus_controller
  import ebc_pkg::*;
;
  logic mclk, rstn, cpu_done, tc_done, access_error, bus_master_tc;
  logic data_oe, address_strobe_n, read_strobe_n, address_hold_n;
  logic upper_byte_write_strobe_n, lower_byte_write_strobe_n;
  logic large_area_select_n, cp_area_select_n, io_window_select_n;
  logic wait_request_n, ae;
  logic [15:0] rdata, data_in, data_out;
  logic [15:0] muxed_addr_data_lines_in, muxed_addr_data_lines_out;
  logic [1:0] muxed_addr_data_lines_oe, slow;
  logic [23:0] addr_out;
  logic [6:0] seen;
  ebc_cfg_t cfg;
  ebc_req_t cpu_req, tc_req;
  int err_count = 0, tests_run = 0, n;
  typedef struct packed {
    logic m;
    logic [23:0] a;
    logic e;
    logic [6:0] s;
  } ebc_row_t;
  ebc_row_t rows [10] = '{
    '{1'b0, 24'h000010, 1'b0, 7'h04}, '{1'b0, 24'hF80020, 1'b0, 7'h44},
    '{1'b0, 24'hFFC030, 1'b0, 7'h24}, '{1'b0, 24'hFFF040, 1'b0, 7'h14},
    '{1'b1, 24'hF80050, 1'b0, 7'h44}, '{1'b1, 24'hFFC060, 1'b0, 7'h24},
    '{1'b1, 24'hFFF070, 1'b0, 7'h14}, '{1'b0, 24'hFA0090, 1'b0, 7'h44},
    '{1'b1, 24'h000080, 1'b1, 7'h00}, '{1'b1, 24'hFA00A0, 1'b1, 7'h00}};
  ebc_top u_dut (.*);
  ebc_mem_model u_mem (.*);
  wire sp = !cfg.select_polarity_invert;
  // ==========================================================
  // Sticky record of every strobe and select seen active
  always @(posedge mclk) begin
    seen = seen | {large_area_select_n ^ sp, cp_area_select_n ^ sp,
      io_window_select_n ^ sp, ~address_strobe_n, ~read_strobe_n,
      ~upper_byte_write_strobe_n, ~lower_byte_write_strobe_n};
  end
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ==========================================================
  // Checks and bus tasks
  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    tests_run++;
    if (g != e) begin
      err_count++;
      $display("CHECK FAILED %0t cycles %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input logic t);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      #1;
      n++;
      ae = access_error;
      if ((t ? tc_done : cpu_done) === 1'b1) return;
    end
    err_count++;
    $display("CHECK FAILED %0t no done", $time);
    print_verdict();
  endtask
  task automatic go(input logic w, input logic [23:0] a,
                    input logic [15:0] d, input logic [1:0] be);
    seen = '0;
    cpu_req = '{1'b1, w, be[1], be[0], a, d};
    wt(1'b0);
    cpu_req.valid = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  initial begin
    rstn = 1'b0;
    cfg = '0;
    cpu_req = '0;
    tc_req = '0;
    slow = 2'h0;
    repeat (11) @(posedge mclk);
    #1;
    chk_v({address_strobe_n, read_strobe_n, upper_byte_write_strobe_n,
      lower_byte_write_strobe_n, large_area_select_n, cp_area_select_n,
      io_window_select_n, address_hold_n, data_oe,
      muxed_addr_data_lines_oe}, 16'h07F8);
    @(posedge mclk);
    #1;
    rstn = 1'b1;
    // Area table: write then read back every decoded window
    cfg.mux_bus_wide = 1'b1;
    cfg.io_window_enable = 1'b1;
    cfg.large_area_enable = 1'b1;
    cfg.cp_area_enable = 1'b1;
    foreach (rows[i]) begin
      cfg.mux_mode_select = rows[i].m;
      go(1'b1, rows[i].a, {rows[i].a[7:0], ~rows[i].a[7:0]}, 2'h3);
      go(1'b0, rows[i].a, 16'h0000, 2'h3);
      chk_v(ae, rows[i].e);
      chk_v(seen, rows[i].s);
      if (!rows[i].e) chk_v(rdata, {rows[i].a[7:0], ~rows[i].a[7:0]});
    end
    // Access lengths, normal mode
    cfg = '0;
    go(1'b0, 24'h000100, 16'h0000, 2'h3);
    chk_n(n, 4);
    cfg.three_state[0] = 1'b1;
    go(1'b0, 24'h000100, 16'h0000, 2'h3);
    chk_n(n, 5);
    cfg.prog_waits[1:0] = 2'h3;
    go(1'b0, 24'h000100, 16'h0000, 2'h3);
    chk_n(n, 8);
    cfg.prog_waits = '0;
    slow = 2'h2;
    go(1'b0, 24'h000100, 16'h0000, 2'h3);
    chk_n(n, 7);
    slow = 2'h0;
    // Multiplexed lengths, hold polarity and narrow bus
    cfg = '0;
    cfg.mux_mode_select = 1'b1;
    cfg.mux_bus_wide = 1'b1;
    go(1'b0, 24'hF80100, 16'h0000, 2'h3);
    chk_n(n, 6);
    cfg.addr_phase_wait_bit = 1'b1;
    go(1'b0, 24'hF80100, 16'h0000, 2'h3);
    chk_n(n, 7);
    cfg.three_state[7] = 1'b1;
    go(1'b0, 24'hF80100, 16'h0000, 2'h3);
    chk_n(n, 8);
    cfg.hold_polarity_invert = 1'b1;
    go(1'b1, 24'hF80104, 16'hC3A6, 2'h3);
    go(1'b0, 24'hF80104, 16'h0000, 2'h3);
    chk_v(rdata, 16'hC3A6);
    cfg.mux_bus_wide = 1'b0;
    go(1'b1, 24'hF80110, 16'h1234, 2'h1);
    go(1'b0, 24'hF80110, 16'h0000, 2'h3);
    chk_v(rdata, 16'h3434);
    // Idle state between read and write
    cfg = '0;
    go(1'b0, 24'h000100, 16'h0000, 2'h3);
    go(1'b1, 24'h000100, 16'h0000, 2'h3);
    chk_n(n, 4);
    cfg.idle_insert = 1'b1;
    go(1'b0, 24'h000100, 16'h0000, 2'h3);
    go(1'b1, 24'h000100, 16'h0000, 2'h3);
    chk_n(n, 5);
    // Burst ROM: first word normal, later words short
    cfg = '0;
    cfg.three_state[0] = 1'b1;
    cfg.burst_rom_enable = 1'b1;
    go(1'b0, 24'h000200, 16'h0000, 2'h3);
    chk_n(n, 5);
    go(1'b0, 24'h000202, 16'h0000, 2'h3);
    chk_n(n, 3);
    cfg.burst_two_state = 1'b1;
    go(1'b0, 24'h000204, 16'h0000, 2'h3);
    chk_n(n, 4);
    // Byte lanes, select polarity and address strobe
    cfg = '0;
    go(1'b1, 24'h000020, 16'hA55A, 2'h2);
    chk_v(seen[1:0], 2'h2);
    go(1'b0, 24'h000020, 16'h0000, 2'h3);
    chk_v(rdata, 16'hA5DF);
    cfg.cp_area_enable = 1'b1;
    cfg.select_polarity_invert = 1'b1;
    // Let the select pins take the new idle level before recording
    @(posedge mclk);
    #1;
    go(1'b0, 24'hFFC030, 16'h0000, 2'h3);
    chk_v(seen, 7'h24);
    go(1'b0, 24'h000010, 16'h0000, 2'h3);
    chk_v(seen[3:2], 2'h3);
    // Arbitration: both masters at once, transfer controller first
    cpu_req = '{1'b1, 1'b0, 1'b1, 1'b1, 24'h000100, 16'h0000};
    tc_req = cpu_req;
    wt(1'b1);
    chk_v({cpu_done, bus_master_tc}, 2'h1);
    tc_req.valid = 1'b0;
    wt(1'b0);
    chk_v(bus_master_tc, 1'b0);
    cpu_req.valid = 1'b0;
    @(posedge mclk);
    print_verdict();
  end
endmodule
